// *** logic/dlp_defs.vh ***
// Overview of operation
// - Forty-two wires per lane group per beat
// - Direction chosen once at initialization
// - Bits 41 frame, 40 parity, 39:36 flags
// - Disabled services free wires as payload
// - Rotated partner reordered on receive only
// - Each flag guards one nine-bit group
// - Frame and parity never inverted or counted
// - Five or more changes: flag high, invert
// - Fewer than five: flag low, pass through
// - Receiver inverts group when flag high
// - Flag wires carry payload when coding off
// - Inversion history cleared at initialization
// - Even parity after encode, before decode
// - Only service combinations zero to four
//
// Purpose: shared constants of the logical phy line coder
// Assumes: gearbox ratio of four, one lane group
// Notes:   definitions only
`ifndef DLP_DEFS_VH
`define DLP_DEFS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DLP_RATIO 4
`define DLP_BEAT_W 42
`define DLP_WORD_W 168
`define DLP_GRP_W 9
`define DLP_GRPS 4
`define DLP_PAY_LO_W 36
`define DLP_FRM_BIT 41
`define DLP_PAR_BIT 40
`define DLP_FLAG_LSB 36
`define DLP_DBI_LIMIT 4'h5
`define DLP_FIFO_DEPTH 4
`define DLP_FIFO_AW 2

// ----------------------------------------
// Service modes and payload widths
// ----------------------------------------
`define DLP_MODE_ALL 3'h0
`define DLP_MODE_DBI 3'h1
`define DLP_MODE_FP 3'h2
`define DLP_MODE_FRM 3'h3
`define DLP_MODE_BYP 3'h4
`define DLP_PLEN_M0 6'h24
`define DLP_PLEN_M1 6'h26
`define DLP_PLEN_M2 6'h28
`define DLP_PLEN_M3 6'h29
`define DLP_PLEN_M4 6'h2a

// ----------------------------------------
// Registers and fields
// ----------------------------------------
`define DLP_REG_CTRL 8'h00
`define DLP_REG_STATUS 8'h04
`define DLP_CTRL_MODE_LSB 0
`define DLP_CTRL_DIR_BIT 3
`define DLP_CTRL_REORD_BIT 4
`define DLP_CTRL_INIT_BIT 8
`define DLP_CTRL_RST 5'h00
`define DLP_ST_INIT_BIT 5
`define DLP_ST_PERR_BIT 6
`define DLP_ST_BADM_BIT 7
`define DLP_ST_LVL_LSB 8

`endif

// *** logic/dlp_fifo.v ***
// Purpose: small first-in first-out buffer for transmit words
// Assumes: depth is a power of two, single clock
// Notes:   flush empties the buffer in one cycle
`default_nettype none

module dlp_fifo #(
	parameter W = 168,
	parameter D = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	input wire flush_i,
	// Filling side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// Draining side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o,
	// Fill level
	output wire [AW:0] level_o
);

reg [W-1:0] mem [0:D-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire push;
wire pop;

// Honest flags straight from the count
assign in_ready_o = (count != D[AW:0]);
assign out_valid_o = (count != {(AW+1){1'b0}});
assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;
assign out_data_o = mem[rd_ptr];
assign level_o = count;

// Storage has no reset, pointers do
always @(posedge clk_i)
begin
	if (push)
		mem[wr_ptr] <= in_data_i;
end

// Pointer and count bookkeeping
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
	end
	else if (flush_i)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
	end
	else
	begin
		if (push)
			wr_ptr <= wr_ptr + 1'b1;
		if (pop)
			rd_ptr <= rd_ptr + 1'b1;
		if (push & ~pop)
			count <= count + 1'b1;
		else if (pop & ~push)
			count <= count - 1'b1;
	end
end

endmodule // dlp_fifo

`default_nettype wire

// *** logic/dlp_logical_phy.v ***
// Purpose: logical phy line coder for one lane group, ratio four
// Assumes: phy gearbox and upper layer share this clock
// Notes:   config takes effect only on the init strobe
//
// The register offsets and the plain strobed port were chosen for this implementation.
`include "dlp_defs.vh"
`default_nettype none

module dlp_logical_phy (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// Register port
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// Upper layer transmit side
	input wire [`DLP_WORD_W-1:0] tx_data_i,
	input wire tx_valid_i,
	output wire tx_ready_o,
	// Gearbox transmit side
	output reg [`DLP_WORD_W-1:0] phy_tx_data_o,
	output reg phy_tx_valid_o,
	input wire phy_tx_ready_i,
	// Gearbox receive side
	input wire [`DLP_WORD_W-1:0] phy_rx_data_i,
	input wire phy_rx_valid_i,
	// Upper layer receive side
	output reg [`DLP_WORD_W-1:0] rx_data_o,
	output reg [`DLP_RATIO-1:0] rx_frame_o,
	output reg rx_valid_o,
	output reg rx_parity_err_o
);

// ----------------------------------------
// Decode helpers
// ----------------------------------------

// Services per mode as {frame, parity, inversion}
function [2:0] dlp_svc;
	input [2:0] mode;
	begin
		case (mode)
			`DLP_MODE_ALL: dlp_svc = 3'h7;
			`DLP_MODE_DBI: dlp_svc = 3'h1;
			`DLP_MODE_FP: dlp_svc = 3'h6;
			`DLP_MODE_FRM: dlp_svc = 3'h4;
			default: dlp_svc = 3'h0;
		endcase
	end
endfunction

// Payload bits per beat for a mode
function [5:0] dlp_plen;
	input [2:0] mode;
	begin
		case (mode)
			`DLP_MODE_ALL: dlp_plen = `DLP_PLEN_M0;
			`DLP_MODE_DBI: dlp_plen = `DLP_PLEN_M1;
			`DLP_MODE_FP: dlp_plen = `DLP_PLEN_M2;
			`DLP_MODE_FRM: dlp_plen = `DLP_PLEN_M3;
			default: dlp_plen = `DLP_PLEN_M4;
		endcase
	end
endfunction

// Count of set bits in a nine-bit group
function [3:0] dlp_ones;
	input [`DLP_GRP_W-1:0] v;
	integer i;
	begin
		dlp_ones = 4'h0;
		for (i = 0; i < `DLP_GRP_W; i = i + 1)
			dlp_ones = dlp_ones + {3'h0, v[i]};
	end
endfunction

// Rotated-die restore; plain wire reversal stands in for the maps
function [`DLP_BEAT_W-1:0] dlp_reorder;
	input [`DLP_BEAT_W-1:0] v;
	integer i;
	begin
		dlp_reorder = {`DLP_BEAT_W{1'b0}};
		for (i = 0; i < `DLP_BEAT_W; i = i + 1)
			dlp_reorder[i] = v[`DLP_BEAT_W-1-i];
	end
endfunction

// ----------------------------------------
// Registers and active configuration
// ----------------------------------------
reg [4:0] ctrl;
reg [2:0] act_mode;
reg act_tx;
reg act_reord;
reg inited;
reg perr_sticky;
reg badm_sticky;
reg [`DLP_PAY_LO_W-1:0] hist;
wire init_req;
wire init_ok;
wire [2:0] svc;
wire frm_on;
wire par_on;
wire dbi_on;
wire [5:0] plen;
wire [`DLP_FIFO_AW:0] fifo_lvl;
wire [31:0] status;
wire wr_ctrl;
wire wr_stat;
reg rx_par_bad;
wire rx_take;

assign wr_ctrl = reg_wr_i & (reg_addr_i == `DLP_REG_CTRL);
assign wr_stat = reg_wr_i & (reg_addr_i == `DLP_REG_STATUS);
assign init_req = wr_ctrl & reg_wdata_i[`DLP_CTRL_INIT_BIT];
// Bad combinations never reach the datapath
assign init_ok = init_req & (reg_wdata_i[2:0] <= `DLP_MODE_BYP);
assign svc = dlp_svc(act_mode);
assign frm_on = svc[2];
assign par_on = svc[1];
assign dbi_on = svc[0];
assign plen = dlp_plen(act_mode);

// Software view of the block state
assign status = {16'h0, 5'h0, fifo_lvl, badm_sticky, perr_sticky, inited,
	act_reord, act_tx, act_mode};

// Control register; the init bit is a strobe and reads zero
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
		ctrl <= `DLP_CTRL_RST;
	else if (wr_ctrl)
		ctrl <= reg_wdata_i[4:0];
end

// Settings latch only at init so every beat sees one setup
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		act_mode <= `DLP_MODE_ALL;
		act_tx <= 1'b0;
		act_reord <= 1'b0;
		inited <= 1'b0;
	end
	else if (init_ok)
	begin
		act_mode <= reg_wdata_i[2:0];
		act_tx <= reg_wdata_i[`DLP_CTRL_DIR_BIT];
		act_reord <= reg_wdata_i[`DLP_CTRL_REORD_BIT];
		inited <= 1'b1;
	end
end

// Sticky errors; a new event beats a same-cycle clear
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		perr_sticky <= 1'b0;
		badm_sticky <= 1'b0;
	end
	else
	begin
		if (rx_par_bad & rx_take)
			perr_sticky <= 1'b1;
		else if (wr_stat & reg_wdata_i[`DLP_ST_PERR_BIT])
			perr_sticky <= 1'b0;
		if (init_req & ~init_ok)
			badm_sticky <= 1'b1;
		else if (wr_stat & reg_wdata_i[`DLP_ST_BADM_BIT])
			badm_sticky <= 1'b0;
	end
end

// Read data stands only in the cycle after the strobe
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
		reg_rdata_o <= 32'h0;
	else if (reg_rd_i && reg_addr_i == `DLP_REG_CTRL)
		reg_rdata_o <= {27'h0, ctrl};
	else if (reg_rd_i && reg_addr_i == `DLP_REG_STATUS)
		reg_rdata_o <= status;
	else
		reg_rdata_o <= 32'h0; // Unmapped reads give zero
end

// ----------------------------------------
// Transmit buffer
// ----------------------------------------
wire tx_on;
wire fifo_in_ready;
wire fifo_valid;
wire [`DLP_WORD_W-1:0] fifo_data;
wire tx_load;

assign tx_on = inited & act_tx;
assign tx_ready_o = fifo_in_ready & tx_on;
// Gearbox back-pressure stalls the drain, so the buffer fills
assign tx_load = fifo_valid & (~phy_tx_valid_o | phy_tx_ready_i);

dlp_fifo #(
	.W(`DLP_WORD_W),
	.D(`DLP_FIFO_DEPTH),
	.AW(`DLP_FIFO_AW)
) u_fifo (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.flush_i(init_req),
	.in_valid_i(tx_valid_i & tx_on),
	.in_ready_o(fifo_in_ready),
	.in_data_i(tx_data_i),
	.out_valid_o(fifo_valid),
	.out_ready_i(tx_load),
	.out_data_o(fifo_data),
	.level_o(fifo_lvl)
);

// ----------------------------------------
// Transmit encoder
// ----------------------------------------
reg [`DLP_WORD_W-1:0] tx_enc;
reg [`DLP_WORD_W-1:0] tx_sh;
reg [`DLP_BEAT_W-1:0] tx_beat;
reg [`DLP_BEAT_W-1:0] tx_d;
reg [`DLP_PAY_LO_W-1:0] tx_run;
reg [`DLP_GRP_W-1:0] tx_grp;
integer tb;
integer tg;

// Beats chain in order; each compares with the one driven before
always @*
begin
	tx_enc = {`DLP_WORD_W{1'b0}};
	tx_sh = {`DLP_WORD_W{1'b0}};
	tx_beat = {`DLP_BEAT_W{1'b0}};
	tx_d = {`DLP_BEAT_W{1'b0}};
	tx_grp = {`DLP_GRP_W{1'b0}};
	tx_run = hist;
	for (tb = 0; tb < `DLP_RATIO; tb = tb + 1)
	begin
		tx_sh = fifo_data >> (tb * plen);
		tx_beat = tx_sh[`DLP_BEAT_W-1:0];
		tx_d = tx_beat;
		case (act_mode)
			`DLP_MODE_ALL: tx_d = {6'h0, tx_beat[35:0]};
			`DLP_MODE_DBI: tx_d = {tx_beat[37:36], 4'h0, tx_beat[35:0]};
			`DLP_MODE_FP: tx_d = {2'h0, tx_beat[39:0]};
			`DLP_MODE_FRM: tx_d = {1'b0, tx_beat[40:0]};
			default: tx_d = tx_beat;
		endcase
		// Marker on the first, least significant beat only
		if (frm_on)
			tx_d[`DLP_FRM_BIT] = (tb == 0);
		if (dbi_on)
		begin
			for (tg = 0; tg < `DLP_GRPS; tg = tg + 1)
			begin
				tx_grp = tx_d[tg*`DLP_GRP_W +: `DLP_GRP_W];
				if (dlp_ones(tx_grp ^ tx_run[tg*`DLP_GRP_W +: `DLP_GRP_W])
					>= `DLP_DBI_LIMIT)
				begin
					tx_d[tg*`DLP_GRP_W +: `DLP_GRP_W] = ~tx_grp;
					tx_d[`DLP_FLAG_LSB+tg] = 1'b1;
				end
				else
					tx_d[`DLP_FLAG_LSB+tg] = 1'b0;
			end
			tx_run = tx_d[`DLP_PAY_LO_W-1:0];
		end
		// Parity covers the wires as driven, inversion included
		if (par_on)
			tx_d[`DLP_PAR_BIT] = ^{tx_d[41], tx_d[39:0]};
		tx_enc[tb*`DLP_BEAT_W +: `DLP_BEAT_W] = tx_d;
	end
end

// History tracks the last beat handed to the gearbox
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
		hist <= {`DLP_PAY_LO_W{1'b0}};
	else if (init_req)
		hist <= {`DLP_PAY_LO_W{1'b0}};
	else if (tx_load)
		hist <= tx_run;
end

// Output stage holds a word until the gearbox takes it
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		phy_tx_data_o <= {`DLP_WORD_W{1'b0}};
		phy_tx_valid_o <= 1'b0;
	end
	else if (init_req)
		phy_tx_valid_o <= 1'b0;
	else if (tx_load)
	begin
		phy_tx_data_o <= tx_enc;
		phy_tx_valid_o <= 1'b1;
	end
	else if (phy_tx_ready_i)
		phy_tx_valid_o <= 1'b0;
end

// ----------------------------------------
// Receive decoder
// ----------------------------------------
reg [`DLP_WORD_W-1:0] rx_word;
reg [`DLP_BEAT_W-1:0] rx_d;
reg [`DLP_BEAT_W-1:0] rx_p;
reg [`DLP_RATIO-1:0] rx_frm;
integer rb;
integer rg;

assign rx_take = phy_rx_valid_i & inited & ~act_tx;

// Order restored first, parity next, inversion undone last
always @*
begin
	rx_word = {`DLP_WORD_W{1'b0}};
	rx_d = {`DLP_BEAT_W{1'b0}};
	rx_p = {`DLP_BEAT_W{1'b0}};
	rx_frm = {`DLP_RATIO{1'b0}};
	rx_par_bad = 1'b0;
	for (rb = 0; rb < `DLP_RATIO; rb = rb + 1)
	begin
		rx_d = phy_rx_data_i[rb*`DLP_BEAT_W +: `DLP_BEAT_W];
		if (act_reord)
			rx_d = dlp_reorder(rx_d);
		if (par_on && (^rx_d))
			rx_par_bad = 1'b1;
		if (dbi_on)
		begin
			for (rg = 0; rg < `DLP_GRPS; rg = rg + 1)
			begin
				if (rx_d[`DLP_FLAG_LSB+rg])
					rx_d[rg*`DLP_GRP_W +: `DLP_GRP_W] =
						~rx_d[rg*`DLP_GRP_W +: `DLP_GRP_W];
			end
		end
		rx_frm[rb] = frm_on & rx_d[`DLP_FRM_BIT];
		case (act_mode)
			`DLP_MODE_ALL: rx_p = {6'h0, rx_d[35:0]};
			`DLP_MODE_DBI: rx_p = {4'h0, rx_d[41:40], rx_d[35:0]};
			`DLP_MODE_FP: rx_p = {2'h0, rx_d[39:0]};
			`DLP_MODE_FRM: rx_p = {1'b0, rx_d[40:0]};
			default: rx_p = rx_d;
		endcase
		rx_word = rx_word | ({126'h0, rx_p} << (rb * plen));
	end
end

// Registered hand-off to the upper layer
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		rx_data_o <= {`DLP_WORD_W{1'b0}};
		rx_frame_o <= {`DLP_RATIO{1'b0}};
		rx_valid_o <= 1'b0;
		rx_parity_err_o <= 1'b0;
	end
	else
	begin
		rx_valid_o <= rx_take;
		rx_parity_err_o <= rx_take & rx_par_bad;
		if (rx_take)
		begin
			rx_data_o <= rx_word;
			rx_frame_o <= rx_frm;
		end
	end
end

endmodule // dlp_logical_phy

`default_nettype wire

// *** verif/dlp_chk_checker.sv ***
// Purpose: port checker for the logical phy line coder
// Assumes: one clock; active config tracked from init writes
// Notes:   bound to the coder at the foot of this file
`include "dlp_defs.vh"
`default_nettype none
module dlp_chk (
	// Clock and registers
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	// Data side
	input wire logic tx_ready_o,
	input wire logic [`DLP_WORD_W-1:0] phy_tx_data_o,
	input wire logic phy_tx_valid_o,
	input wire logic phy_tx_ready_i,
	input wire logic [`DLP_WORD_W-1:0] phy_rx_data_i,
	input wire logic phy_rx_valid_i,
	input wire logic [`DLP_WORD_W-1:0] rx_data_o,
	input wire logic rx_valid_o,
	input wire logic rx_parity_err_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] mode;
	logic inited, tx_dir, reord;
	logic [9:0] rx_g0;
	wire ini = reg_wr_i && reg_addr_i == `DLP_REG_CTRL && reg_wdata_i[`DLP_CTRL_INIT_BIT];
	wire frm = mode == 3'h0 || mode == 3'h2 || mode == 3'h3;
	wire par = mode == 3'h0 || mode == 3'h2;
	wire dbi = mode < 3'h2;
	// Active config; an illegal mode leaves it alone
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			{inited, tx_dir, reord, mode} <= 6'h00;
		else if (ini && reg_wdata_i[2:0] < 3'h5)
			{inited, tx_dir, reord, mode} <= {1'b1, reg_wdata_i[3], reg_wdata_i[4], reg_wdata_i[2:0]};
	// First group and its flag, one cycle late
	always_ff @(posedge clk_i)
		rx_g0 <= {phy_rx_data_i[36], phy_rx_data_i[8:0]};
	// Every beat even over all 42 wires
	function automatic bit par_ok(input logic [`DLP_WORD_W-1:0] d);
		par_ok = 1'b1;
		for (int b = 0; b < 4; b++)
			if (^d[b*42+:42])
				par_ok = 1'b0;
	endfunction
	// No group toggles more than four wires beat to beat
	function automatic bit dbi_ok(input logic [`DLP_WORD_W-1:0] d);
		dbi_ok = 1'b1;
		for (int b = 1; b < 4; b++)
			for (int g = 0; g < 4; g++)
				if ($countones(d[b*42+g*9+:9] ^ d[b*42+g*9-42+:9]) > 4)
					dbi_ok = 1'b0;
	endfunction
	// ------
	// Checks
	// ------
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_frame_marker:
		assert property (phy_tx_valid_o && frm |-> phy_tx_data_o[41] && !phy_tx_data_o[83]
			&& !phy_tx_data_o[125] && !phy_tx_data_o[167]) else $error("frame bit misplaced");
	a_parity_even:
		assert property (phy_tx_valid_o && par |-> par_ok(phy_tx_data_o))
			else $error("odd parity beat");
	a_group_toggle:
		assert property (phy_tx_valid_o && dbi |-> dbi_ok(phy_tx_data_o))
			else $error("group toggles over four");
	a_hold_stall:
		assert property (phy_tx_valid_o && !phy_tx_ready_i && !ini
			|=> phy_tx_valid_o && $stable(phy_tx_data_o)) else $error("word dropped in stall");
	a_rx_answer:
		assert property (phy_rx_valid_i && inited && !tx_dir && !ini |=> rx_valid_o)
			else $error("receive word lost");
	a_rx_source:
		assert property (rx_valid_o |-> $past(phy_rx_valid_i))
			else $error("receive pulse without word");
	a_tx_refused:
		assert property (!(inited && tx_dir) |-> !tx_ready_o)
			else $error("transmit taken in wrong state");
	a_perr_pulse:
		assert property (rx_parity_err_o |-> rx_valid_o && par)
			else $error("parity error out of place");
	a_rx_invert:
		assert property (rx_valid_o && dbi && !reord |-> rx_data_o[8:0] == (rx_g0[8:0] ^ {9{rx_g0[9]}}))
			else $error("group not restored");
endmodule // dlp_chk
bind dlp_logical_phy dlp_chk i_chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.tx_ready_o, .phy_tx_data_o, .phy_tx_valid_o, .phy_tx_ready_i, .phy_rx_data_i,
	.phy_rx_valid_i, .rx_data_o, .rx_valid_o, .rx_parity_err_o);
`default_nettype wire

// *** verif/dlp_gbox.sv ***
// Purpose: gearbox stand-in on the far side of the coder
// Assumes: same clock as the coder
// Notes:   released receive lines show the inverse word
`default_nettype none
module dlp_gbox (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Pacing
	input wire logic stall_i,
	input wire logic slow_i,
	// Words from the coder
	input wire logic [167:0] tx_data_i,
	input wire logic tx_valid_i,
	output var logic tx_ready_o,
	// Words to the coder
	output var logic [167:0] rx_data_o,
	output var logic rx_valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [167:0] got [$];
	// Whole four-beat words; slow pace accepts every other cycle
	always @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			tx_ready_o <= 1'b0;
		else
		begin
			if (tx_valid_i && tx_ready_o)
				got.push_back(tx_data_i);
			tx_ready_o <= !stall_i && (!slow_i || !tx_ready_o);
		end
	// One cycle per word, then the lines are let go
	task automatic send(input logic [167:0] w);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= w;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~w;
	endtask
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = '0;
	end
endmodule // dlp_gbox
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the logical phy line coder
// Assumes: ratio four, one lane group, 20 MHz clock
// Notes:   expected words come from a local encoder model
`include "dlp_defs.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, tx_valid_i, tx_ready_o, stall, slow;
	logic phy_tx_valid_o, phy_tx_ready_i, phy_rx_valid_i, rx_valid_o, rx_parity_err_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic [3:0] rx_frame_o;
	logic [167:0] tx_data_i, phy_tx_data_o, phy_rx_data_i, rx_data_o, pw;
	logic [167:0] words [5];
	logic [41:0] hist;
	int err_count, tests_run;
	dlp_logical_phy i_dut (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .tx_data_i, .tx_valid_i, .tx_ready_o, .phy_tx_data_o, .phy_tx_valid_o,
		.phy_tx_ready_i, .phy_rx_data_i, .phy_rx_valid_i, .rx_data_o, .rx_frame_o, .rx_valid_o,
		.rx_parity_err_o);
	dlp_gbox i_gb (.clk_i, .rst_b_i, .stall_i(stall), .slow_i(slow), .tx_data_i(phy_tx_data_o),
		.tx_valid_i(phy_tx_valid_o), .tx_ready_o(phy_tx_ready_i), .rx_data_o(phy_rx_data_i),
		.rx_valid_o(phy_rx_valid_i));
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// --------------
	// Helpers
	// --------------
	task automatic end_sim;
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [167:0] got, input logic [167:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic give_up;
		$display("BAD %0t wait ran out", $time);
		err_count++;
		end_sim;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic put(input logic [167:0] d);
		int n;
		@(posedge clk_i);
		tx_valid_i <= 1'b1;
		tx_data_i <= d;
		#1;
		n = 0;
		while (!tx_ready_o)
		begin
			if (++n > 200)
				give_up;
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
	endtask
	task automatic cfg(input int m, input bit tx, input bit r);
		hist = '0;
		wr(8'h00, 32'h100 | m | tx << 3 | r << 4);
	endtask
	function automatic int plen(input int m);
		plen = m == 0 ? 36 : m == 1 ? 38 : m == 2 ? 40 : m == 3 ? 41 : 42;
	endfunction
	// Beat bit i taken from bit 41-i, as a rotated partner wires it
	function automatic logic [167:0] rev(input logic [167:0] x);
		for (int i = 0; i < 168; i++)
			rev[i] = x[i - i % 42 + 41 - i % 42];
	endfunction
	// Reference line coder; history follows the driven groups
	function automatic logic [167:0] enc(input int m, input logic [167:0] w);
		logic [41:0] p;
		for (int b = 0; b < 4; b++)
		begin
			p = 42'(w >> (b * plen(m))) & ~({42{1'b1}} << plen(m));
			if (m < 2)
			begin
				p[41:36] = {p[37:36], 4'h0};
				for (int g = 0; g < 4; g++)
					if ($countones(p[g*9+:9] ^ hist[g*9+:9]) > 4)
					begin
						p[g*9+:9] = ~p[g*9+:9];
						p[36+g] = 1'b1;
					end
				hist = p;
			end
			if (m != 1 && m != 4)
				p[41] = (b == 0);
			if (m == 0 || m == 2)
				p[40] = ^{p[41], p[39:0]};
			enc[b*42+:42] = p;
		end
	endfunction
	// --------------
	// Main sequence
	// --------------
	initial
	begin
		int n;
		bit r;
		{rst_b_i, reg_wr_i, reg_rd_i, tx_valid_i, stall, slow} = '0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		tx_data_i = '0;
		err_count = 0;
		tests_run = 0;
		words = '{'0, '1, {24'h0, {8{9'h00f, 9'h01f}}}, {21{8'ha5}}, {24'h0, {8{9'h1f0, 9'h1e0}}}};
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		chk(tx_ready_o, 1'b0);
		// Transmit in every mode; stalled in mode 0, slow-paced in modes 1 and 3
		for (int m = 0; m < 5; m++)
		begin
			stall <= (m == 0);
			slow <= m[0];
			cfg(m, 1, 0);
			rd(8'h00, m + 8);
			rd(8'h04, m + 32'h28);
			foreach (words[i])
				put(words[i]);
			if (m == 0)
				rd(8'h04, 32'h428);
			#1 chk(tx_ready_o, m != 0);
			stall <= 1'b0;
			n = 0;
			while (i_gb.got.size() < 5)
			begin
				if (++n > 500)
					give_up;
				@(posedge clk_i);
			end
			foreach (words[i])
				chk(i_gb.got.pop_front(), enc(m, words[i]));
		end
		// Illegal mode refused, sticky flag cleared by writing one
		wr(8'h00, 32'h10d);
		rd(8'h04, 32'hac);
		wr(8'h04, 32'h80);
		rd(8'h04, 32'h2c);
		// Receive in every mode, reordered in bypass
		for (int m = 0; m < 5; m++)
		begin
			r = (m == 4);
			cfg(m, 0, r);
			rd(8'h04, m + r * 16 + 32'h20);
			chk(tx_ready_o, 1'b0);
			foreach (words[i])
			begin
				pw = enc(m, words[i]);
				i_gb.send(r ? rev(pw) : pw);
				#1 chk(rx_valid_o, 1'b1);
				chk(rx_data_o, words[i] & ~('1 << 4 * plen(m)));
				chk(rx_frame_o, m == 1 || m == 4 ? 4'h0 : 4'h1);
				chk(rx_parity_err_o, 1'b0);
			end
		end
		// Corrupted parity bit is flagged and kept
		cfg(0, 0, 0);
		pw = enc(0, words[3]);
		pw[40] = ~pw[40];
		i_gb.send(pw);
		#1 chk(rx_parity_err_o, 1'b1);
		rd(8'h04, 32'h60);
		end_sim;
	end
endmodule // testbench
`default_nettype wire
